// >>> shared/irq_flags_pkg.sv
// constants, types and carriers for the peripheral interrupt flag block
// =====================================================================
// Function
// - flags set regardless of any enable
// - requests need the peripheral group enable
// - enable register two bit layout
// - enables read write, zero at reset
// - flag register one layout, bit7 zero
// - conversion flag sticky until written zero
// - receive flag read-only, mirrors buffer full
// - transmit flag read-only, mirrors buffer empty
// - sync port flag on transfer complete
// - master sequence completion sets sync flag
// - idle start/stop in multi-master sets flag
// - capture sets capture/compare flag
// - compare match sets flag, pwm unused
// - timer two match flag sticky
// - timer one overflow flag sticky
// - flag register two mirrors enable layout
// - oscillator fail after switch sets flag
// - comparator output change sets flag
// - nonvolatile write done sets flag
// - bus collision in master mode sets flag
// - low-power wake-up sets sticky flag
package irq_flags_pkg;

  // =====================================================================
  // register map
  localparam int ADDR_W = 2;
  localparam logic [1:0] OFS_ENABLE_2 = 2'h0;
  localparam logic [1:0] OFS_FLAGS_1 = 2'h1;
  localparam logic [1:0] OFS_FLAGS_2 = 2'h2;
  localparam logic [7:0] RST_ENABLE_2 = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // =====================================================================
  // field positions
  localparam int F1_CONV = 6;
  localparam int F1_RX = 5;
  localparam int F1_TX = 4;
  localparam int F1_SYNC = 3;
  localparam int F1_CC1 = 2;
  localparam int F1_T2 = 1;
  localparam int F1_T1 = 0;
  localparam int F2_OSC = 7;
  localparam int F2_CMP2 = 6;
  localparam int F2_CMP1 = 5;
  localparam int F2_NV = 4;
  localparam int F2_BCOL = 3;
  localparam int F2_WAKE = 2;
  localparam int F2_CC2 = 0;
  localparam logic [7:0] IMPL_1 = 8'h7F;
  localparam logic [7:0] RO_1 = 8'h30;
  localparam logic [7:0] IMPL_2 = 8'hFD;
  localparam logic [7:0] RO_2 = 8'h00;

  // =====================================================================
  // modes
  typedef enum logic [1:0] {SYNC_SPI, SYNC_I2C_SLAVE, SYNC_I2C_MASTER} sync_mode_t;
  typedef enum logic [1:0] {CC_OFF, CC_CAPTURE, CC_COMPARE, CC_PWM} capcmp_mode_t;

  // =====================================================================
  // carriers
  typedef struct packed {
    logic we;
    logic re;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic conv_done;
    logic rx_full;
    logic tx_empty;
    logic sync_xfer_done;
    logic sync_seq_done;
    logic sync_bus_start;
    logic sync_bus_stop;
    logic sync_idle;
    logic multi_master;
    logic bus_collision;
    logic cc1_capture;
    logic cc1_match;
    logic cc2_capture;
    logic cc2_match;
    logic timer_two_match;
    logic timer_one_overflow;
    logic osc_failed;
    logic clk_on_internal;
    logic comparator_one_output;
    logic comparator_two_output;
    logic nv_write_done;
    logic wake_event;
  } periph_events_t;

  typedef struct packed {
    logic [7:0] q;
  } flag_state_t;

  typedef struct packed {
    logic [7:0] rd_data;
    logic irq;
    logic [7:0] enable2;
    logic cmp1_prev;
    logic cmp2_prev;
    logic osc_prev;
  } ctrl_state_t;

endpackage

// >>> rtl/flag_bank.sv
// one 8-bit request flag register with sticky set, software write and mirrored bits
module flag_bank #(
  parameter logic [7:0] IMPL = 8'hFF,
  parameter logic [7:0] RO = 8'h00
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] set,
  input wire logic [7:0] level,
  input wire logic wr,
  input wire logic [7:0] wr_data,
  output logic [7:0] flags
);

  irq_flags_pkg::flag_state_t st_q;
  irq_flags_pkg::flag_state_t st_d;

  // =====================================================================
  // next state
  always_comb begin
    st_d = st_q;
    if (wr) begin
      st_d.q = wr_data;
    end
    // event beats a clearing write in the same cycle
    st_d.q = st_d.q | set;
    // read-only bits just follow their source
    st_d.q = (st_d.q & ~RO) | (level & RO);
    // unimplemented bits stay zero
    st_d.q = st_d.q & IMPL;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{q: irq_flags_pkg::RST_FLAGS};
    end else begin
      st_q <= st_d;
    end
  end

  assign flags = st_q.q;

endmodule

// >>> rtl/periph_irq_flags.sv
// peripheral interrupt enable and request flag registers with request output
module periph_irq_flags (
  input wire logic clk,
  input wire logic rst_n,
  input wire irq_flags_pkg::reg_req_t req,
  output logic [7:0] rd_data,
  input wire irq_flags_pkg::periph_events_t ev,
  input wire irq_flags_pkg::sync_mode_t sync_mode,
  input wire irq_flags_pkg::capcmp_mode_t cc1_mode,
  input wire irq_flags_pkg::capcmp_mode_t cc2_mode,
  input wire logic [7:0] enable1,
  input wire logic periph_group_enable,
  input wire logic global_irq_enable,
  output logic periph_irq
);

  irq_flags_pkg::ctrl_state_t st_q;
  irq_flags_pkg::ctrl_state_t st_d;

  logic [7:0] flags1;
  logic [7:0] flags2;
  logic [7:0] set1;
  logic [7:0] set2;
  logic [7:0] lvl1;
  logic wr_f1;
  logic wr_f2;

  // =====================================================================
  // qualified event sources
  logic sync_set;
  logic bcol_set;
  logic cc1_set;
  logic cc2_set;
  logic cmp1_set;
  logic cmp2_set;
  logic osc_now;
  logic osc_set;
  logic is_master;

  assign is_master = (sync_mode == irq_flags_pkg::SYNC_I2C_MASTER);

  // sync port: transfer complete in any mode
  always_comb begin
    sync_set = ev.sync_xfer_done;
    // master-initiated start, stop, restart or ack done
    if (is_master && ev.sync_seq_done) begin
      sync_set = 1'b1;
    end
    // foreign start/stop seen while idle, multi-master only
    if (ev.multi_master && ev.sync_idle && (ev.sync_bus_start || ev.sync_bus_stop)) begin
      if (sync_mode != irq_flags_pkg::SYNC_SPI) begin
        sync_set = 1'b1;
      end
    end
  end

  // collision only matters when we drive the bus as master
  assign bcol_set = is_master & ev.bus_collision;

  // capture/compare unit one
  always_comb begin
    case (cc1_mode)
      irq_flags_pkg::CC_CAPTURE: cc1_set = ev.cc1_capture;
      irq_flags_pkg::CC_COMPARE: cc1_set = ev.cc1_match;
      irq_flags_pkg::CC_PWM: cc1_set = 1'b0;
      irq_flags_pkg::CC_OFF: cc1_set = 1'b0;
      default: cc1_set = 1'b0;
    endcase
  end

  // capture/compare unit two
  always_comb begin
    case (cc2_mode)
      irq_flags_pkg::CC_CAPTURE: cc2_set = ev.cc2_capture;
      irq_flags_pkg::CC_COMPARE: cc2_set = ev.cc2_match;
      irq_flags_pkg::CC_PWM: cc2_set = 1'b0;
      irq_flags_pkg::CC_OFF: cc2_set = 1'b0;
      default: cc2_set = 1'b0;
    endcase
  end

  // any toggle of a comparator output, either direction
  assign cmp1_set = ev.comparator_one_output ^ st_q.cmp1_prev;
  assign cmp2_set = ev.comparator_two_output ^ st_q.cmp2_prev;

  // flag once the failure has been followed by the clock switch
  assign osc_now = ev.osc_failed & ev.clk_on_internal;
  assign osc_set = osc_now & ~st_q.osc_prev;

  // =====================================================================
  // set vectors, laid out as the flag registers
  always_comb begin
    set1 = 8'h00;
    set1[irq_flags_pkg::F1_CONV] = ev.conv_done;
    set1[irq_flags_pkg::F1_SYNC] = sync_set;
    set1[irq_flags_pkg::F1_CC1] = cc1_set;
    set1[irq_flags_pkg::F1_T2] = ev.timer_two_match;
    set1[irq_flags_pkg::F1_T1] = ev.timer_one_overflow;
  end

  always_comb begin
    lvl1 = 8'h00;
    lvl1[irq_flags_pkg::F1_RX] = ev.rx_full;
    lvl1[irq_flags_pkg::F1_TX] = ev.tx_empty;
  end

  always_comb begin
    set2 = 8'h00;
    set2[irq_flags_pkg::F2_OSC] = osc_set;
    set2[irq_flags_pkg::F2_CMP2] = cmp2_set;
    set2[irq_flags_pkg::F2_CMP1] = cmp1_set;
    set2[irq_flags_pkg::F2_NV] = ev.nv_write_done;
    set2[irq_flags_pkg::F2_BCOL] = bcol_set;
    set2[irq_flags_pkg::F2_WAKE] = ev.wake_event;
    set2[irq_flags_pkg::F2_CC2] = cc2_set;
  end

  // =====================================================================
  // register writes
  assign wr_f1 = req.we && (req.addr == irq_flags_pkg::OFS_FLAGS_1);
  assign wr_f2 = req.we && (req.addr == irq_flags_pkg::OFS_FLAGS_2);

  // sticky flags set whatever the enables say
  flag_bank #(
    .IMPL(irq_flags_pkg::IMPL_1),
    .RO(irq_flags_pkg::RO_1)
  ) u_flags1 (
    .clk(clk),
    .rst_n(rst_n),
    .set(set1),
    .level(lvl1),
    .wr(wr_f1),
    .wr_data(req.wdata),
    .flags(flags1)
  );

  // same bit positions as enable register two
  flag_bank #(
    .IMPL(irq_flags_pkg::IMPL_2),
    .RO(irq_flags_pkg::RO_2)
  ) u_flags2 (
    .clk(clk),
    .rst_n(rst_n),
    .set(set2),
    .level(8'h00),
    .wr(wr_f2),
    .wr_data(req.wdata),
    .flags(flags2)
  );

  // =====================================================================
  // control state
  logic pend1;
  logic pend2;

  // enable-one bit positions match flag register one
  assign pend1 = |(flags1 & enable1 & irq_flags_pkg::IMPL_1);
  assign pend2 = |(flags2 & st_q.enable2);

  always_comb begin
    st_d = st_q;
    st_d.cmp1_prev = ev.comparator_one_output;
    st_d.cmp2_prev = ev.comparator_two_output;
    st_d.osc_prev = osc_now;
    // enables are plain storage, bit 1 held at zero
    if (req.we && (req.addr == irq_flags_pkg::OFS_ENABLE_2)) begin
      st_d.enable2 = req.wdata & irq_flags_pkg::IMPL_2;
    end
    // read data valid only in the cycle after the strobe
    st_d.rd_data = 8'h00;
    if (req.re) begin
      case (req.addr)
        irq_flags_pkg::OFS_ENABLE_2: st_d.rd_data = st_q.enable2;
        irq_flags_pkg::OFS_FLAGS_1: st_d.rd_data = flags1;
        irq_flags_pkg::OFS_FLAGS_2: st_d.rd_data = flags2;
        default: st_d.rd_data = 8'h00;
      endcase
    end
    // both gates from the core must be open
    st_d.irq = global_irq_enable & periph_group_enable & (pend1 | pend2);
  end

  // comparator history loads zero at reset; a high output then
  // raises its flag on the first clock, which matches a power-up edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{
        rd_data: 8'h00,
        irq: 1'b0,
        enable2: irq_flags_pkg::RST_ENABLE_2,
        cmp1_prev: 1'b0,
        cmp2_prev: 1'b0,
        osc_prev: 1'b0
      };
    end else begin
      st_q <= st_d;
    end
  end

  assign rd_data = st_q.rd_data;
  assign periph_irq = st_q.irq;

endmodule

// >>> test/event_source.sv
// behavioural model of the on-chip peripheral event sources feeding the flag block
module event_source (
  input wire logic clk,
  input wire logic [21:0] drive,
  output irq_flags_pkg::periph_events_t ev
);
  timeunit 1ns;
  timeprecision 1ps;
  // =====================================================================
  // events
  // sources fire regardless of any enable, like the real peripherals
  always_ff @(posedge clk) begin
    ev <= irq_flags_pkg::periph_events_t'(drive);
  end
endmodule

// >>> test/periph_irq_flags_chk.sv
// concurrent checks on the ports of the peripheral interrupt flag block
module periph_irq_flags_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire irq_flags_pkg::reg_req_t req,
  input wire logic [7:0] rd_data,
  input wire irq_flags_pkg::periph_events_t ev,
  input wire logic [7:0] enable1,
  input wire logic periph_group_enable,
  input wire logic global_irq_enable,
  input wire logic periph_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // =====================================================================
  // register reads
  rd_idle_a: assert property (!$past(req.re) |-> rd_data == 8'h00)
    else $error("read data not zero outside a read");
  rd_unmapped_a: assert property ($past(req.re && req.addr == 2'h3) |-> rd_data == 8'h00)
    else $error("unmapped read returned data");
  flags_top_a: assert property ($past(req.re && req.addr == 2'h1) |-> !rd_data[7])
    else $error("top bit of flags one reads one");
  bit1_zero_a: assert property ($past(req.re && req.addr != 2'h1) |-> !rd_data[1])
    else $error("unused bit one reads one");
  overflow_sets_a: assert property (ev.timer_one_overflow ##1 (req.re && req.addr == 2'h1) |=> rd_data[0])
    else $error("overflow flag not set");
  rx_mirror_a: assert property ((req.re && req.addr == 2'h1 && $past(ev.rx_full) && $past(ev.rx_full, 2))
    |=> rd_data[5])
    else $error("receive flag does not follow buffer");
  // =====================================================================
  // request output
  irq_gate_a: assert property (!$past(global_irq_enable && periph_group_enable) |-> !periph_irq)
    else $error("request without both gates");
  irq_raise_a: assert property ((global_irq_enable && periph_group_enable && enable1[0]
    && $past(ev.timer_one_overflow)) |=> periph_irq)
    else $error("enabled flag raised no request");
endmodule

bind periph_irq_flags periph_irq_flags_chk periph_irq_flags_chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .req(req),
  .rd_data(rd_data),
  .ev(ev),
  .enable1(enable1),
  .periph_group_enable(periph_group_enable),
  .global_irq_enable(global_irq_enable),
  .periph_irq(periph_irq)
);

// >>> test/tb_top.sv
// self-checking testbench for the peripheral interrupt flag block
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  irq_flags_pkg::reg_req_t req = '0;
  logic [7:0] rd_data;
  irq_flags_pkg::periph_events_t ev;
  logic [21:0] drv = '0;
  irq_flags_pkg::sync_mode_t sync_mode = irq_flags_pkg::SYNC_I2C_MASTER;
  irq_flags_pkg::capcmp_mode_t cc1_mode = irq_flags_pkg::CC_CAPTURE;
  irq_flags_pkg::capcmp_mode_t cc2_mode = irq_flags_pkg::CC_COMPARE;
  logic [7:0] enable1 = 8'h00;
  logic group_en = 1'b0;
  logic global_en = 1'b0;
  logic periph_irq;
  logic [7:0] got;
  int fail_count = 0;
  int checks = 0;
  int cyc = 0;
  always #2 clk = ~clk;
  periph_irq_flags periph_irq_flags_i (.clk(clk), .rst_n(rst_n), .req(req), .rd_data(rd_data), .ev(ev),
    .sync_mode(sync_mode), .cc1_mode(cc1_mode), .cc2_mode(cc2_mode), .enable1(enable1),
    .periph_group_enable(group_en), .global_irq_enable(global_en), .periph_irq(periph_irq));
  event_source event_source_i (.clk(clk), .drive(drv), .ev(ev));
  // =====================================================================
  // bus and event tasks
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk);
    req <= '0;
    #1 got = rd_data;
    `CHK(got, exp)
  endtask
  task automatic fire(input logic [21:0] v);
    @(posedge clk);
    drv <= drv | v;
    @(posedge clk);
    drv <= drv & ~v;
  endtask
  task automatic ev_chk(input logic [21:0] v, input logic [1:0] a, input logic [7:0] exp);
    fire(v);
    rd(a, exp);
    wr(a, 8'h00);
  endtask
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk);
    #1 `CHK(periph_irq, exp)
  endtask
  task automatic stop_test();
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // =====================================================================
  // timeout, far above the few hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  // =====================================================================
  // sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h1, 8'h00);
    rd(2'h2, 8'h00);
    wr(2'h0, 8'hFF);
    rd(2'h0, 8'hFD);
    wr(2'h0, 8'h00);
    rd(2'h0, 8'h00);
    wr(2'h3, 8'hFF);
    rd(2'h3, 8'h00);
    wr(2'h1, 8'hFF);
    rd(2'h1, 8'h4F);
    wr(2'h1, 8'h00);
    wr(2'h2, 8'hFF);
    rd(2'h2, 8'hFD);
    wr(2'h2, 8'h00);
    ev_chk(22'h200000, 2'h1, 8'h40);
    ev_chk(22'h040000, 2'h1, 8'h08);
    ev_chk(22'h020000, 2'h1, 8'h08);
    ev_chk(22'h016000, 2'h1, 8'h08);
    ev_chk(22'h000800, 2'h1, 8'h04);
    ev_chk(22'h000100, 2'h2, 8'h01);
    ev_chk(22'h000080, 2'h1, 8'h02);
    ev_chk(22'h000040, 2'h1, 8'h01);
    ev_chk(22'h000030, 2'h2, 8'h80);
    ev_chk(22'h000008, 2'h2, 8'h20);
    ev_chk(22'h000004, 2'h2, 8'h40);
    ev_chk(22'h000002, 2'h2, 8'h10);
    ev_chk(22'h001000, 2'h2, 8'h08);
    ev_chk(22'h000001, 2'h2, 8'h04);
    // spi mode: only a finished transfer may raise the port flag
    sync_mode <= irq_flags_pkg::SYNC_SPI;
    cc1_mode <= irq_flags_pkg::CC_COMPARE;
    cc2_mode <= irq_flags_pkg::CC_CAPTURE;
    ev_chk(22'h040000, 2'h1, 8'h08);
    ev_chk(22'h020000, 2'h1, 8'h00);
    ev_chk(22'h016000, 2'h1, 8'h00);
    ev_chk(22'h001000, 2'h2, 8'h00);
    ev_chk(22'h000400, 2'h1, 8'h04);
    ev_chk(22'h000800, 2'h1, 8'h00);
    ev_chk(22'h000200, 2'h2, 8'h01);
    sync_mode <= irq_flags_pkg::SYNC_I2C_SLAVE;
    cc2_mode <= irq_flags_pkg::CC_OFF;
    ev_chk(22'h00E000, 2'h1, 8'h08);
    ev_chk(22'h00C000, 2'h1, 8'h00);
    ev_chk(22'h020000, 2'h1, 8'h00);
    ev_chk(22'h000100, 2'h2, 8'h00);
    cc1_mode <= irq_flags_pkg::CC_PWM;
    ev_chk(22'h000800, 2'h1, 8'h00);
    // falling comparator output must set the flag as well
    @(posedge clk);
    drv <= 22'h000008;
    repeat (3) @(posedge clk);
    wr(2'h2, 8'h00);
    drv <= '0;
    repeat (2) @(posedge clk);
    rd(2'h2, 8'h20);
    wr(2'h2, 8'h00);
    @(posedge clk);
    drv <= 22'h100000;
    repeat (2) @(posedge clk);
    rd(2'h1, 8'h20);
    wr(2'h1, 8'h00);
    rd(2'h1, 8'h20);
    @(posedge clk);
    drv <= 22'h080000;
    repeat (2) @(posedge clk);
    rd(2'h1, 8'h10);
    @(posedge clk);
    drv <= '0;
    repeat (2) @(posedge clk);
    rd(2'h1, 8'h00);
    wr(2'h1, 8'h00);
    @(posedge clk);
    enable1 <= 8'h01;
    global_en <= 1'b1;
    fire(22'h000040);
    irq_is(1'b0);
    @(posedge clk);
    group_en <= 1'b1;
    irq_is(1'b1);
    wr(2'h1, 8'h00);
    irq_is(1'b0);
    fire(22'h000040);
    irq_is(1'b1);
    @(posedge clk);
    global_en <= 1'b0;
    irq_is(1'b0);
    wr(2'h1, 8'h00);
    wr(2'h0, 8'h04);
    global_en <= 1'b1;
    irq_is(1'b0);
    fire(22'h000001);
    irq_is(1'b1);
    wr(2'h0, 8'h00);
    irq_is(1'b0);
    rd(2'h2, 8'h04);
    // reset in mid-run with enables and a flag standing
    wr(2'h0, 8'hFF);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(2'h0, 8'h00);
    rd(2'h2, 8'h00);
    irq_is(1'b0);
    stop_test();
  end
endmodule
